// ### src/spsc_ctrl.sv
// Serial port controller: master/slave engine, select lines, clocking, FIFOs
`timescale 1ns/1ns
module spsc_ctrl import spsc_pkg::*; #(
    parameter int DEPTH = 8,
    parameter int DIV_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // PLL rate enable pulse, same clock domain
    input wire logic pll_tick,
    // Serial clock pin
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe,
    // Data pins
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe,
    // Select pins
    input wire logic select_line_0_i,
    output logic [NSEL-1:0] select_line_o,
    output logic [NSEL-1:0] select_line_oe
);
    localparam int PW = $clog2(DEPTH);

    // Configuration
    logic go_q, rxneg_q, txneg_q, lsb_q, clkp_q, slave_q, flag_q;
    logic [LEN_W-1:0] len_q;
    logic [DIV_W-1:0] div_q;
    logic [NSEL-1:0] select_line_bits_q;
    logic lvl_q, auto_q, trig_q, lmatch_q, compat_q, src_q;
    // Engine
    spsc_state_e st_q;
    logic [DIV_W-1:0] hc_q;
    logic sclk_q, dout_q;
    logic [6:0] ec_q;
    logic [5:0] rcnt_q, tcnt_q;
    logic [DATA_W-1:0] txw_q, rxw_q;
    logic act_prev_q, sclk_prev_q;
    // FIFOs
    logic [DATA_W-1:0] tx_mem [DEPTH];
    logic [DATA_W-1:0] rx_mem [DEPTH];
    logic [PW:0] tw_q, tr_q, rw_q, rr_q;

    // Pin synchronisers, a change counts once stages two and three agree
    logic [3:0] pin_raw, pin_f;
    assign pin_raw = {miso_i, mosi_i, select_line_0_i, sclk_i};
    for (genvar g = 0; g < 4; g++) begin : g_sync
        logic [SYNC_N-1:0] s_q;
        logic f_q;
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                s_q <= '0;
                f_q <= 1'b0;
            end else begin
                s_q <= {s_q[SYNC_N-2:0], pin_raw[g]};
                if (s_q[1] == s_q[2]) begin
                    f_q <= s_q[2];
                end
            end
        end
        assign pin_f[g] = f_q;
    end

    // Decode
    logic wr_ctrl, wr_tx, rd_rx;
    assign wr_ctrl = reg_wr && reg_addr == OFF_CTRL;
    assign wr_tx = reg_wr && reg_addr == OFF_TX;
    assign rd_rx = reg_rd && reg_addr == OFF_RX;

    logic tx_empty, tx_full, rx_empty, rx_full;
    assign tx_empty = tw_q == tr_q;
    assign tx_full = tw_q == {~tr_q[PW], tr_q[PW-1:0]};
    assign rx_empty = rw_q == rr_q;
    assign rx_full = rw_q == {~rr_q[PW], rr_q[PW-1:0]};

    logic [5:0] wlen;
    assign wlen = (len_q == LEN_RST) ? MAX_LEN : {1'b0, len_q};

    // Slave view of the select input
    logic ss_act, ss_on, ss_off;
    assign ss_act = pin_f[1] == lvl_q;
    assign ss_on = ss_act && !act_prev_q;
    assign ss_off = !ss_act && act_prev_q;

    // Engine clock: source select, then divisor
    logic src_tick, half_tick;
    logic [DIV_W-1:0] hlim;
    assign src_tick = src_q ? pll_tick : 1'b1;
    // New rate: divisor+1 per half period; compatible rate halves the divisor
    assign hlim = compat_q ? (div_q >> 1) : div_q;
    // Fastest serial clock is half the bus clock, never above it
    assign half_tick = src_tick && hc_q >= hlim;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hc_q <= '0;
        end else if (st_q == ST_IDLE || half_tick) begin
            hc_q <= '0;
        end else if (src_tick) begin
            hc_q <= hc_q + 1'b1;
        end
    end

    // Edge events, shared by both roles
    logic busy, ev, rise, samp, drv, din, word_end, quiet, start;
    assign busy = st_q == ST_XFER;
    always_comb begin
        if (slave_q) begin
            ev = busy && pin_f[0] != sclk_prev_q;
            rise = pin_f[0];
            din = pin_f[2];
        end else begin
            ev = busy && half_tick;
            rise = ~sclk_q;
            din = pin_f[3];
        end
    end
    assign samp = ev && (rise ^ rxneg_q) && rcnt_q < wlen;
    assign drv = ev && (rise ^ txneg_q);

    // Word termination per role and trigger type
    always_comb begin
        word_end = 1'b0;
        if (busy) begin
            if (!slave_q) begin
                word_end = ec_q == {wlen, 1'b0};
            end else if (trig_q) begin
                word_end = rcnt_q == wlen || !ss_act;
            end else begin
                word_end = ss_off;
            end
        end
    end
    // A select drop with no bit moved is not a word
    assign quiet = slave_q && rcnt_q == '0;

    always_comb begin
        start = 1'b0;
        if (st_q == ST_IDLE && go_q) begin
            if (!slave_q) begin
                start = 1'b1;
            end else if (trig_q) begin
                start = ss_act;
            end else begin
                start = ss_on;
            end
        end
    end

    function automatic logic [4:0] bit_idx(input logic [5:0] c, input logic [5:0] n,
                                           input logic lsb);
        logic [5:0] r;
        r = lsb ? c : n - 6'd1 - c;
        return r[4:0];
    endfunction

    // Transfer state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= ST_IDLE;
            ec_q <= '0;
            rcnt_q <= '0;
            tcnt_q <= '0;
            txw_q <= '0;
            rxw_q <= '0;
        end else if (start) begin
            st_q <= ST_XFER;
            ec_q <= '0;
            rcnt_q <= '0;
            tcnt_q <= '0;
            rxw_q <= '0;
            txw_q <= tx_empty ? '0 : tx_mem[tr_q[PW-1:0]];
        end else if (word_end) begin
            st_q <= ST_IDLE;
        end else if (busy) begin
            if (ev) begin
                ec_q <= ec_q + 1'b1;
            end
            if (samp) begin
                rxw_q[bit_idx(rcnt_q, wlen, lsb_q)] <= din;
                rcnt_q <= rcnt_q + 1'b1;
            end
            if (drv) begin
                tcnt_q <= rcnt_q;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            act_prev_q <= 1'b0;
            sclk_prev_q <= 1'b0;
        end else begin
            act_prev_q <= ss_act;
            sclk_prev_q <= pin_f[0];
        end
    end

    // Serial clock and data outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_q <= 1'b0;
            dout_q <= 1'b0;
        end else begin
            if (!busy) begin
                sclk_q <= clkp_q;
            end else if (ev && !slave_q) begin
                sclk_q <= ~sclk_q;
            end
            dout_q <= (tcnt_q < wlen) ? txw_q[bit_idx(tcnt_q, wlen, lsb_q)] : 1'b0;
        end
    end
    assign sclk_o = sclk_q;
    assign sclk_oe = ~slave_q;
    assign mosi_o = dout_q;
    assign mosi_oe = ~slave_q;
    assign miso_o = dout_q;
    assign miso_oe = slave_q && ss_act;

    // Select outputs, one per line
    for (genvar g = 0; g < NSEL; g++) begin : g_sel
        logic o_q;
        logic on;
        // Auto: enabled lines during a word; manual: bit itself
        assign on = select_line_bits_q[g] && (!auto_q || busy);
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                o_q <= 1'b1;
            end else begin
                o_q <= on ? lvl_q : ~lvl_q;
            end
        end
        assign select_line_o[g] = o_q;
        assign select_line_oe[g] = ~slave_q;
    end

    // Transmit FIFO
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tw_q <= '0;
            tr_q <= '0;
        end else begin
            if (wr_tx && !tx_full) begin
                tw_q <= tw_q + 1'b1;
            end
            if (start && !tx_empty) begin
                tr_q <= tr_q + 1'b1;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (wr_tx && !tx_full) begin
            tx_mem[tw_q[PW-1:0]] <= reg_wdata;
        end
    end

    // Receive FIFO; a word arriving while full is dropped
    logic rx_push;
    assign rx_push = word_end && !quiet && !rx_full;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rw_q <= '0;
            rr_q <= '0;
        end else begin
            if (rx_push) begin
                rw_q <= rw_q + 1'b1;
            end
            if (rd_rx && !rx_empty) begin
                rr_q <= rr_q + 1'b1;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (rx_push) begin
            rx_mem[rw_q[PW-1:0]] <= rxw_q;
        end
    end

    // Go bit and unit-transfer flag: a set wins over a clear
    logic more;
    assign more = (tw_q - tr_q) != '0;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            go_q <= 1'b0;
            flag_q <= 1'b0;
            lmatch_q <= 1'b0;
        end else begin
            if (wr_ctrl && reg_wdata[CTRL_GO]) begin
                go_q <= 1'b1;
            end else if (word_end && !quiet) begin
                go_q <= more;
            end
            if (word_end && !quiet) begin
                flag_q <= 1'b1;
            end else if (wr_ctrl && reg_wdata[CTRL_FLAG]) begin
                flag_q <= 1'b0;
            end
            if (word_end && !quiet && trig_q && slave_q) begin
                lmatch_q <= rcnt_q == wlen;
            end
        end
    end

    // Configuration writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxneg_q <= 1'b0;
            txneg_q <= 1'b0;
            len_q <= LEN_RST;
            lsb_q <= 1'b0;
            clkp_q <= 1'b0;
            slave_q <= 1'b0;
            div_q <= DIV_W'(DIV_RST);
            select_line_bits_q <= SEL_RST;
            lvl_q <= 1'b0;
            auto_q <= 1'b0;
            trig_q <= 1'b0;
            compat_q <= 1'b0;
            src_q <= 1'b0;
        end else if (reg_wr) begin
            case (reg_addr)
                OFF_CTRL: begin
                    rxneg_q <= reg_wdata[CTRL_RXNEG];
                    txneg_q <= reg_wdata[CTRL_TXNEG];
                    len_q <= reg_wdata[CTRL_LEN +: LEN_W];
                    lsb_q <= reg_wdata[CTRL_LSB];
                    clkp_q <= reg_wdata[CTRL_CLKP];
                    slave_q <= reg_wdata[CTRL_SLAVE];
                end
                OFF_DIV: div_q <= reg_wdata[DIV_W-1:0];
                OFF_SSR: begin
                    select_line_bits_q <= reg_wdata[SSR_SEL +: NSEL];
                    lvl_q <= reg_wdata[SSR_LVL];
                    auto_q <= reg_wdata[SSR_AUTO];
                    trig_q <= reg_wdata[SSR_TRIG];
                end
                OFF_CTRL2: compat_q <= reg_wdata[CTRL2_COMPAT];
                OFF_CLKSEL: src_q <= reg_wdata[CLKSEL_SRC];
                default: ;
            endcase
        end
    end

    // Read data, valid the cycle after the strobe
    logic [DATA_W-1:0] rd_d;
    always_comb begin
        rd_d = '0;
        case (reg_addr)
            OFF_CTRL: begin
                rd_d[CTRL_GO] = go_q || busy;
                rd_d[CTRL_RXNEG] = rxneg_q;
                rd_d[CTRL_TXNEG] = txneg_q;
                rd_d[CTRL_LEN +: LEN_W] = len_q;
                rd_d[CTRL_LSB] = lsb_q;
                rd_d[CTRL_CLKP] = clkp_q;
                rd_d[CTRL_FLAG] = flag_q;
                rd_d[CTRL_SLAVE] = slave_q;
            end
            OFF_DIV: rd_d[DIV_W-1:0] = div_q;
            OFF_SSR: begin
                rd_d[SSR_SEL +: NSEL] = select_line_bits_q;
                rd_d[SSR_LVL] = lvl_q;
                rd_d[SSR_AUTO] = auto_q;
                rd_d[SSR_TRIG] = trig_q;
                rd_d[SSR_LMATCH] = lmatch_q;
            end
            OFF_STAT: begin
                rd_d[STAT_RXE] = rx_empty;
                rd_d[STAT_RXF] = rx_full;
                rd_d[STAT_TXE] = tx_empty;
                rd_d[STAT_TXF] = tx_full;
                rd_d[STAT_BUSY] = busy;
            end
            OFF_RX: rd_d = rx_mem[rr_q[PW-1:0]];
            OFF_CTRL2: rd_d[CTRL2_COMPAT] = compat_q;
            OFF_CLKSEL: rd_d[CLKSEL_SRC] = src_q;
            default: rd_d = '0;
        endcase
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= rd_d;
        end else begin
            reg_rdata <= '0;
        end
    end
endmodule

// ### src/spsc_pkg.sv
// Package: register map, field positions and constants of the serial port
package spsc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // Register offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DIV = 8'h04;
    localparam logic [7:0] OFF_SSR = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0C;
    localparam logic [7:0] OFF_RX = 8'h10;
    localparam logic [7:0] OFF_TX = 8'h20;
    localparam logic [7:0] OFF_CTRL2 = 8'h3C;
    localparam logic [7:0] OFF_CLKSEL = 8'h40;
    // serial_ctrl_reg fields
    localparam int CTRL_GO = 0;
    localparam int CTRL_RXNEG = 1;
    localparam int CTRL_TXNEG = 2;
    localparam int CTRL_LEN = 3;
    localparam int LEN_W = 5;
    localparam int CTRL_LSB = 10;
    localparam int CTRL_CLKP = 11;
    localparam int CTRL_FLAG = 16;
    localparam int CTRL_SLAVE = 18;
    // select_ctrl_reg fields
    localparam int SSR_SEL = 0;
    localparam int SSR_LVL = 2;
    localparam int SSR_AUTO = 3;
    localparam int SSR_TRIG = 4;
    localparam int SSR_LMATCH = 5;
    // serial_ctrl2_reg and system_clock_select_reg fields
    localparam int CTRL2_COMPAT = 31;
    localparam int CLKSEL_SRC = 0;
    // Status fields
    localparam int STAT_RXE = 0;
    localparam int STAT_RXF = 1;
    localparam int STAT_TXE = 2;
    localparam int STAT_TXF = 3;
    localparam int STAT_BUSY = 4;
    // Reset values
    localparam logic [15:0] DIV_RST = 16'h0000;
    localparam logic [1:0] SEL_RST = 2'h0;
    localparam logic [LEN_W-1:0] LEN_RST = 5'h00;
    // Full word length; a zero length field means this
    localparam logic [5:0] MAX_LEN = 6'h20;
    localparam int SYNC_N = 3;
    localparam int NSEL = 2;
    typedef enum logic [0:0] {ST_IDLE, ST_XFER} spsc_state_e;
endpackage

// ### tb/spsc_monitor.sv
// Checker: role, select and serial clock relations at the controller ports
`timescale 1ns/1ns
module spsc_monitor import spsc_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register writes
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    // Pins
    input wire logic sclk_o,
    input wire logic sclk_oe,
    input wire logic miso_oe,
    input wire logic [NSEL-1:0] select_line_o,
    input wire logic [NSEL-1:0] select_line_oe
);
    logic [5:0] ssr_q, ssr_p;
    logic slave_q, comp_q, src_q, sclk_q;
    logic [15:0] div_q, hcnt_q;
    wire wr_ctrl = reg_wr && reg_addr == OFF_CTRL;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Shadow settings; the lagged copy lines up with registered pins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ssr_q <= 6'h00;
            ssr_p <= 6'h00;
            slave_q <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == OFF_SSR) ssr_q <= reg_wdata[5:0];
            ssr_p <= ssr_q;
            if (wr_ctrl) slave_q <= reg_wdata[CTRL_SLAVE];
        end
    end
    // Compat taken as set until written, so no rate check on a guess
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_q <= DIV_RST;
            comp_q <= 1'b1;
            src_q <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == OFF_DIV) div_q <= reg_wdata[15:0];
            if (reg_wr && reg_addr == OFF_CTRL2) comp_q <= reg_wdata[CTRL2_COMPAT];
            if (reg_wr && reg_addr == OFF_CLKSEL) src_q <= reg_wdata[CLKSEL_SRC];
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_q <= 1'b0;
            hcnt_q <= 16'hFFFF;
        end else begin
            sclk_q <= sclk_o;
            if (sclk_o != sclk_q) hcnt_q <= 16'h0001;
            else if (hcnt_q != 16'hFFFF) hcnt_q <= hcnt_q + 16'h0001;
        end
    end
    sequence s_go_cmd;
        reg_wr && reg_addr == OFF_CTRL && reg_wdata[CTRL_GO] && !reg_wdata[CTRL_SLAVE];
    endsequence
    sequence s_sel_on;
        ((select_line_o ^ {NSEL{~ssr_q[SSR_LVL]}}) & ssr_q[1:0]) == ssr_q[1:0];
    endsequence
    property p_role;
        wr_ctrl |-> ##2 sclk_oe == !slave_q;
    endproperty
    a_role: assert property (p_role) else $error("role outputs wrong");
    property p_oe_pair;
        select_line_oe == {NSEL{sclk_oe}};
    endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("select enables wrong");
    property p_miso_oe;
        miso_oe |-> slave_q && !sclk_oe;
    endproperty
    a_miso_oe: assert property (p_miso_oe) else $error("slave out outside slave");
    property p_manual;
        !slave_q && ssr_p == ssr_q && !ssr_q[SSR_AUTO]
            |-> select_line_o == (ssr_q[SSR_LVL] ? ssr_q[1:0] : ~ssr_q[1:0]);
    endproperty
    a_manual: assert property (p_manual) else $error("manual select wrong");
    property p_auto_only;
        !slave_q && ssr_p == ssr_q && ssr_q[SSR_AUTO]
            |-> ((select_line_o ^ {NSEL{~ssr_q[SSR_LVL]}}) & ~ssr_q[1:0]) == 2'h0;
    endproperty
    a_auto_only: assert property (p_auto_only) else $error("disabled select active");
    property p_go_select;
        s_go_cmd ##0 ssr_q[SSR_AUTO] |-> ##[1:6] s_sel_on;
    endproperty
    a_go_select: assert property (p_go_select) else $error("auto select late");
    property p_sclk_rate;
        sclk_oe && !src_q && !comp_q && $changed(sclk_o) |-> hcnt_q >= div_q + 16'h0001;
    endproperty
    a_sclk_rate: assert property (p_sclk_rate) else $error("serial clock too fast");
    property p_rst_rest;
        $fell(rst) |-> (select_line_o == {NSEL{1'b1}}) ##1 $stable(sclk_o)[*8];
    endproperty
    a_rst_rest: assert property (p_rst_rest) else $error("not at rest after reset");
endmodule
bind spsc_ctrl spsc_monitor spsc_monitor_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .sclk_o(sclk_o), .sclk_oe(sclk_oe),
    .miso_oe(miso_oe), .select_line_o(select_line_o), .select_line_oe(select_line_oe));

// ### tb/spsc_peer.sv
// Off-chip peripheral: active-low selected shift register slave
`timescale 1ns/1ns
module spsc_peer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link pins
    input wire logic sclk,
    input wire logic mosi,
    input wire logic sel_n,
    output logic miso,
    // Test side
    input wire logic [7:0] pat,
    output logic [7:0] got
);
    logic sclk_q, sel_q;
    logic [2:0] idx_q;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_q <= 1'b0;
            sel_q <= 1'b1;
            idx_q <= 3'h6;
            miso <= 1'b0;
            got <= 8'h00;
        end else begin
            sclk_q <= sclk;
            sel_q <= sel_n;
            if (sel_n) begin
                // Released line toggles so a stale bit never reads as data
                miso <= ~miso;
                idx_q <= 3'h6;
            end else if (sel_q) begin
                miso <= pat[7];
            end else if (sclk_q && !sclk) begin
                miso <= pat[idx_q];
                idx_q <= idx_q - 3'h1;
            end
            if (!sel_n && !sclk_q && sclk) got <= {got[6:0], mosi};
        end
    end
endmodule

// ### tb/testbench.sv
// Testbench: register, master link and slave select scenarios
`timescale 1ns/1ns
module testbench import spsc_pkg::*; ;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = 8'h00;
    logic [DATA_W-1:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic pll_tick = 1'b0;
    logic sclk_i = 1'b0;
    logic mosi_i = 1'b0;
    logic ss0_i = 1'b1;
    logic [7:0] pat = 8'h00;
    logic [DATA_W-1:0] reg_rdata;
    logic sclk_o, mosi_o, miso_i;
    logic [NSEL-1:0] select_line_o;
    logic [7:0] got;
    logic [1:0] rd_p = 2'h0;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    int fails = 0;
    int check_count = 0;
    always #5 clk = ~clk;
    spsc_ctrl spsc_ctrl_i (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pll_tick(pll_tick),
        .sclk_i(sclk_i), .sclk_o(sclk_o), .sclk_oe(), .mosi_i(mosi_i), .mosi_o(mosi_o),
        .mosi_oe(), .miso_i(miso_i), .miso_o(), .miso_oe(), .select_line_0_i(ss0_i),
        .select_line_o(select_line_o), .select_line_oe());
    spsc_peer spsc_peer_i (.clk(clk), .rst(rst), .sclk(sclk_o), .mosi(mosi_o),
        .sel_n(select_line_o[0]), .miso(miso_i), .pat(pat), .got(got));
    function automatic logic [7:0] rev8(input logic [7:0] x);
        for (int i = 0; i < 8; i++) rev8[i] = x[7-i];
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Each read leaves its expectation for the watcher below
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                      output logic [31:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    always @(posedge clk) begin
        pll_tick <= 1'($urandom);
        rd_p <= {rd_p[0], reg_rd};
        // Read data stand only in the cycle after the strobe
        if (rd_p[0]) chk("read data", reg_rdata & msk_q.pop_front(), exp_q.pop_front());
    end
    initial begin
        logic [31:0] v;
        logic [7:0] d;
        int n;
        void'($urandom(32'hCFF3));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("select idle", select_line_o, 32'h3);
        rd(OFF_CTRL, 32'h0, 32'h0005_0001, v);
        rd(8'hF0, 32'h0, 32'hFFFF_FFFF, v);
        for (int k = 0; k < 8; k++) begin
            wr(OFF_SSR, k);
            repeat (3) @(posedge clk);
            chk("manual select", select_line_o, 2'(k[2] ? k[1:0] : ~k[1:0]));
        end
        wr(OFF_CTRL2, 32'h0);
        wr(OFF_CLKSEL, 32'h0);
        wr(OFF_DIV, 32'h7);
        wr(OFF_SSR, 32'h9);
        for (int l = 0; l < 2; l++) begin
            d = 8'($urandom);
            pat <= 8'($urandom);
            wr(OFF_TX, {24'h0, d});
            // Go, transmit on falling edge, eight bits
            wr(OFF_CTRL, 32'h45 | (l << CTRL_LSB));
            n = 0;
            do begin
                rd(OFF_CTRL, 32'h0, 32'h0, v);
                n++;
            end while (v[CTRL_GO] && n < 200);
            if (n >= 200) begin
                fails++;
                conclude();
            end
            rd(OFF_RX, l ? rev8(pat) : pat, 32'hFF, v);
            chk("peer data", got, l ? rev8(d) : d);
            chk("auto release", select_line_o, 32'h3);
        end
        // Slave, level trigger: full word first, then an aborted one
        wr(OFF_DIV, 32'h0);
        wr(OFF_SSR, 32'h10);
        for (int b = 8; b >= 3; b -= 5) begin
            d = 8'($urandom);
            wr(OFF_CTRL, 32'h0005_0045);
            ss0_i <= 1'b0;
            repeat (8) @(posedge clk);
            for (int i = 0; i < b; i++) begin
                mosi_i <= d[7-i];
                repeat (6) @(posedge clk);
                sclk_i <= 1'b1;
                repeat (6) @(posedge clk);
                sclk_i <= 1'b0;
            end
            repeat (6) @(posedge clk);
            ss0_i <= 1'b1;
            repeat (16) @(posedge clk);
            rd(OFF_CTRL, 32'h0001_0000, 32'h0001_0000, v);
            rd(OFF_SSR, b == 8 ? 32'h20 : 32'h0, 32'h20, v);
            if (b == 8) rd(OFF_RX, d, 32'hFF, v);
        end
        conclude();
    end
endmodule
